// >>> rtl/rlc_lane_regs.sv
// ============================================================================
// rlc_lane_regs - lane b3 output and signal-detect configuration registers
// ============================================================================
// sits behind the management bus engine and eeprom loader, which both drive
// the same single-cycle write and read strobes; the analog lane reads the
// decoded settings below.
//
// Functional notes
// - bit 7 of the de-emphasis register reads 1 when lane b3 input is 50 ohm terminated, else 0.
// - the 3-bit de-emphasis field resets to 2 and codes 0..7 mean 0,-1.5,-3.5,-5,-6,-8,-9,-12 dB.
// - threshold bits 3:2 select assert level 50, 40, 75 or 58 mVp-p, with 50 as default.
// - threshold bits 1:0 select de-assert level 37, 22, 55 or 45 mVp-p, with 37 as default.
// - register thresholds apply only while the override bit is set, otherwise the pin rules.
// - control bits 5 and 4 enable the high threshold range for lanes 0-3 and 4-7.
// - control bits 3 and 2 enable fast detection (about 3-4 ns) for lanes 0-3 and 4-7.
// - control bits 1 and 0 enable reduced detect gain for lanes 0-3 and 4-7.
`timescale 1ns/1ps

module rlc_lane_regs (
    input  wire logic       clk_in,
    input  wire logic       rst_n_in,
    // internal register port from the bus engine or eeprom loader
    input  wire logic       reg_wr_en_in,
    input  wire logic       reg_rd_en_in,
    input  wire logic [7:0] reg_addr_in,
    input  wire logic [7:0] reg_wdata_in,
    output logic      [7:0] reg_rdata_out,
    // override enable held in the shared override control register
    input  wire logic       threshold_override_in,
    // asynchronous inputs from pins and the analog front end
    input  wire logic [1:0] detect_threshold_select_in,
    input  wire logic       receiver_presence_sense_in,
    // decoded settings toward the analog lane
    output logic      [2:0] output_deemphasis_out,
    output logic      [7:0] deemph_tenth_db_out,
    output logic      [10:0] output_swing_scale_out,
    output logic      [7:0] assert_thresh_mv_out,
    output logic      [7:0] deassert_thresh_mv_out,
    output logic      [1:0] high_range_en_out,
    output logic      [1:0] fast_detect_en_out,
    output logic      [1:0] reduced_gain_en_out
);
    import rlc_pkg::*;

    // ========================================================================
    // synchronisers for pin and analog inputs
    // ========================================================================
    logic [1:0] pin_s1_q;
    logic [1:0] pin_s2_q;
    logic       pres_s1_q;
    logic       pres_s2_q;

    // two flops each; only the second stage feeds logic
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            pin_s1_q  <= 2'h0;
            pin_s2_q  <= 2'h0;
            pres_s1_q <= 1'b0;
            pres_s2_q <= 1'b0;
        end
        else
        begin
            pin_s1_q  <= detect_threshold_select_in;
            pin_s2_q  <= pin_s1_q;
            pres_s1_q <= receiver_presence_sense_in;
            pres_s2_q <= pres_s1_q;
        end
    end

    // ========================================================================
    // register storage and read-back
    // ========================================================================
    logic [2:0] deemph_d;
    logic [2:0] deemph_q;
    logic [3:0] thresh_d;
    logic [3:0] thresh_q;
    logic [5:0] ctrl_d;
    logic [5:0] ctrl_q;
    logic [7:0] rdata_d;
    logic [7:0] rdata_q;
    logic [7:0] ctrl_view;

    // reserved bits are not stored at all, so stray writes cannot reach the lane
    always_comb
    begin
        deemph_d  = deemph_q;
        thresh_d  = thresh_q;
        ctrl_d    = ctrl_q;
        rdata_d   = rdata_q;
        ctrl_view = {1'b0, 1'b1, ctrl_q};
        if (reg_wr_en_in)
        begin
            if (reg_addr_in == RLC_OFS_DEEMPH)
                deemph_d = reg_wdata_in[RLC_POS_DEEMPH_HI:0];
            if (reg_addr_in == RLC_OFS_THRESH)
                thresh_d = reg_wdata_in[3:0];
            // control write; bits 7 and 6 are fixed
            if (reg_addr_in == RLC_OFS_SD_CTRL)
                ctrl_d = reg_wdata_in[5:0];
        end
        if (reg_rd_en_in)
        begin
            // reserved registers and bits read as zero, except control bit 6, which reads as one
            case (reg_addr_in)
                RLC_OFS_DEEMPH:  rdata_d = {pres_s2_q, 4'h0, deemph_q};
                RLC_OFS_THRESH:  rdata_d = {4'h0, thresh_q};
                RLC_OFS_SD_CTRL: rdata_d = ctrl_view;
                default:         rdata_d = RLC_RDATA_NONE;
            endcase
        end
    end

    // read data holds until the next read strobe
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            deemph_q <= RLC_RST_DEEMPH;
            thresh_q <= RLC_RST_THRESH;
            ctrl_q   <= RLC_RST_SD_CTRL[5:0];
            rdata_q  <= RLC_RDATA_NONE;
        end
        else
        begin
            deemph_q <= deemph_d;
            thresh_q <= thresh_d;
            ctrl_q   <= ctrl_d;
            rdata_q  <= rdata_d;
        end
    end

    assign reg_rdata_out = rdata_q;

    // ========================================================================
    // decoded lane settings
    // ========================================================================
    logic [2:0]  deemph_out_q;
    logic [7:0]  tenth_d;
    logic [7:0]  tenth_q;
    logic [10:0] scale_d;
    logic [10:0] scale_q;
    logic [5:0]  grp_q;
    logic [1:0]  assert_code;
    logic [1:0]  deassert_code;

    always_comb
    begin
        tenth_d = RLC_DEEMPH_TENTH[deemph_q];
        // swing range shrinks by the selected dB
        scale_d = RLC_SWING_SCALE[deemph_q];
        // pin code applies to both levels until override is set
        assert_code   = threshold_override_in ? thresh_q[RLC_POS_ASSERT_LO +: 2] : pin_s2_q;
        deassert_code = threshold_override_in ? thresh_q[RLC_POS_DEASRT_LO +: 2] : pin_s2_q;
    end

    // one register stage so every output comes from a flop
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            deemph_out_q <= RLC_RST_DEEMPH;
            tenth_q      <= RLC_DEEMPH_TENTH[RLC_RST_DEEMPH];
            scale_q      <= RLC_SWING_SCALE[RLC_RST_DEEMPH];
            grp_q        <= RLC_RST_SD_CTRL[5:0];
        end
        else
        begin
            deemph_out_q <= deemph_q;
            tenth_q      <= tenth_d;
            scale_q      <= scale_d;
            grp_q        <= ctrl_q;
        end
    end

    assign output_deemphasis_out  = deemph_out_q;
    assign deemph_tenth_db_out    = tenth_q;
    assign output_swing_scale_out = scale_q;
    // high range per lane group, index 1 is lanes 0-3
    assign high_range_en_out      = grp_q[RLC_POS_HIGH_LO +: 2];
    // fast detect; the 3-4 ns response lives in the analog path
    assign fast_detect_en_out     = grp_q[RLC_POS_FAST_LO +: 2];
    assign reduced_gain_en_out    = grp_q[RLC_POS_GAIN_LO +: 2];

    rlc_thresh_map #(
        .IS_ASSERT (1'b1)
    ) u_assert_map (
        .clk_in   (clk_in),
        .rst_n_in (rst_n_in),
        .code_in  (assert_code),
        .mv_out   (assert_thresh_mv_out)
    );

    rlc_thresh_map #(
        .IS_ASSERT (1'b0)
    ) u_deassert_map (
        .clk_in   (clk_in),
        .rst_n_in (rst_n_in),
        .code_in  (deassert_code),
        .mv_out   (deassert_thresh_mv_out)
    );

    // ========================================================================
    // checks
    // ========================================================================
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rst_n_in);

    a_presence_read: assert property (
        reg_rd_en_in && reg_addr_in == RLC_OFS_DEEMPH
        |=> reg_rdata_out[RLC_POS_PRESENCE] == $past(pres_s2_q)
            && reg_rdata_out[6:3] == 4'h0)
        else $error("termination status read wrong");

    a_deemph_write: assert property (
        reg_wr_en_in && reg_addr_in == RLC_OFS_DEEMPH
        |=> ##1 output_deemphasis_out == $past(reg_wdata_in[2:0], 2))
        else $error("de-emphasis write did not reach output");

    a_swing_zero_db: assert property (
        output_deemphasis_out == 3'h0 |-> output_swing_scale_out == RLC_SWING_FULL)
        else $error("swing range reduced at 0 dB");

    a_swing_max_cut: assert property (
        output_deemphasis_out == 3'h7 |-> output_swing_scale_out == 11'h101
            && deemph_tenth_db_out == 8'h78)
        else $error("swing range wrong at -12 dB");

    a_assert_thresh_reg: assert property (
        (threshold_override_in && thresh_q[3:2] == 2'h2)[*2]
        |=> assert_thresh_mv_out == 8'h4B)
        else $error("assert threshold not 75 mV");

    a_deassert_pin: assert property (
        (!threshold_override_in && pin_s2_q == 2'h0)
        |=> deassert_thresh_mv_out == 8'h25)
        else $error("pin did not govern de-assert threshold");

    a_group_flags: assert property (
        $past(reg_wr_en_in && reg_addr_in == RLC_OFS_SD_CTRL, 2)
        |-> {high_range_en_out, fast_detect_en_out, reduced_gain_en_out}
            == $past(reg_wdata_in[5:0], 2))
        else $error("lane group enables did not follow write");

    a_ctrl_fixed: assert property (
        reg_rd_en_in && reg_addr_in == RLC_OFS_SD_CTRL
        |=> reg_rdata_out[7:6] == 2'h1)
        else $error("control reserved bits read wrong");

    a_rsvd_ignored: assert property (
        reg_rd_en_in && (reg_addr_in == RLC_OFS_RSVD_A || reg_addr_in == RLC_OFS_RSVD_B)
        |=> reg_rdata_out == RLC_RDATA_NONE)
        else $error("reserved register read nonzero");

    c_deemph_max: cover property (
        reg_wr_en_in && reg_addr_in == RLC_OFS_DEEMPH && reg_wdata_in[2:0] == 3'h7);
    c_override_rise: cover property ($rose(threshold_override_in));
    c_presence_seen: cover property (
        reg_rd_en_in && reg_addr_in == RLC_OFS_DEEMPH && pres_s2_q);
    c_fast_on: cover property (fast_detect_en_out == 2'h3);

endmodule : rlc_lane_regs

// >>> rtl/rlc_thresh_map.sv
// ============================================================================
// rlc_thresh_map - maps a 2-bit detect threshold code to millivolts
// ============================================================================
// one copy serves the assert level, another the de-assert level.
// assumes the code is already synchronous to clk_in.
`timescale 1ns/1ps

module rlc_thresh_map #(
    parameter bit IS_ASSERT = 1'b1
) (
    input  wire logic       clk_in,
    input  wire logic       rst_n_in,
    input  wire logic [1:0] code_in,
    output logic      [7:0] mv_out
);
    import rlc_pkg::*;

    logic [7:0] mv_d;
    logic [7:0] mv_q;

    // table lookup; default level comes from code zero in both tables
    always_comb
    begin
        mv_d = IS_ASSERT ? RLC_ASSERT_MV[code_in] : RLC_DEASRT_MV[code_in];
    end

    // registered so the analog comparator sees a glitch-free level
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            mv_q <= IS_ASSERT ? RLC_ASSERT_MV[0] : RLC_DEASRT_MV[0];
        else
            mv_q <= mv_d;
    end

    assign mv_out = mv_q;

endmodule : rlc_thresh_map

// >>> shared/rlc_pkg.sv
// ============================================================================
// rlc_pkg - constants for the lane b3 configuration register slice
// ============================================================================
// holds register offsets, field positions, reset values and decode tables.
// assumes 8-bit registers reached over an 8-bit internal register port.
package rlc_pkg;

    // ========================================================================
    // register offsets
    // ========================================================================
    localparam logic [7:0] RLC_OFS_DEEMPH     = 8'h26;
    localparam logic [7:0] RLC_OFS_THRESH     = 8'h27;
    localparam logic [7:0] RLC_OFS_SD_CTRL    = 8'h28;
    localparam logic [7:0] RLC_OFS_RSVD_A     = 8'h29;
    localparam logic [7:0] RLC_OFS_RSVD_B     = 8'h2A;

    // ========================================================================
    // field positions
    // ========================================================================
    localparam int         RLC_POS_PRESENCE   = 7;   // read-only termination status
    localparam int         RLC_POS_DEEMPH_HI  = 2;
    localparam int         RLC_POS_ASSERT_LO  = 2;   // assert threshold [3:2]
    localparam int         RLC_POS_DEASRT_LO  = 0;   // de-assert threshold [1:0]
    localparam int         RLC_POS_RSVD1      = 6;   // control bit that reads as one
    localparam int         RLC_POS_HIGH_LO    = 4;   // high range [5:4]
    localparam int         RLC_POS_FAST_LO    = 2;   // fast detect [3:2]
    localparam int         RLC_POS_GAIN_LO    = 0;   // reduced gain [1:0]

    // ========================================================================
    // reset values
    // ========================================================================
    localparam logic [2:0] RLC_RST_DEEMPH     = 3'h2;
    localparam logic [3:0] RLC_RST_THRESH     = 4'h0;
    localparam logic [7:0] RLC_RST_SD_CTRL    = 8'h4C;
    localparam logic [7:0] RLC_RDATA_NONE     = 8'h00;

    // ========================================================================
    // decode tables
    // ========================================================================
    // de-emphasis in tenths of a dB, index is the 3-bit code
    localparam logic [7:0] RLC_DEEMPH_TENTH [0:7] =
        '{8'h00, 8'h0F, 8'h23, 8'h32, 8'h3C, 8'h50, 8'h5A, 8'h78};
    // remaining swing range as a fraction of 1024 (10^(-dB/20))
    localparam logic [10:0] RLC_SWING_SCALE [0:7] =
        '{11'h400, 11'h35D, 11'h2AC, 11'h240, 11'h201, 11'h198, 11'h16B, 11'h101};
    localparam logic [10:0] RLC_SWING_FULL    = 11'h400;
    // detect thresholds in mVp-p, index is the 2-bit code
    localparam logic [7:0] RLC_ASSERT_MV [0:3] = '{8'h32, 8'h28, 8'h4B, 8'h3A};
    localparam logic [7:0] RLC_DEASRT_MV [0:3] = '{8'h25, 8'h16, 8'h37, 8'h2D};

endpackage : rlc_pkg

// >>> sim/rlc_far_side.sv
// ============================================================================
// rlc_far_side - far-side model: threshold pin, override bit, termination sense
// assumes the bench requests levels; each level moves on a rising clock edge
`timescale 1ns/1ps

module rlc_far_side (
    input  wire logic       clk_in,
    input  wire logic       rst_n_in,
    input  wire logic       presence_req_in,
    input  wire logic [1:0] pin_code_req_in,
    input  wire logic       override_req_in,
    output logic            receiver_presence_sense_out,
    output logic      [1:0] detect_threshold_select_out,
    output logic            threshold_override_out
);
    // ========================================================================
    // pin and status levels
    // ========================================================================
    // override gates pin
    // termination status source
    // override resets low so the pin rules until software takes over
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            receiver_presence_sense_out <= 1'b0;
            detect_threshold_select_out <= 2'h0;
            threshold_override_out      <= 1'b0;
        end
        else
        begin
            receiver_presence_sense_out <= presence_req_in;
            detect_threshold_select_out <= pin_code_req_in;
            threshold_override_out      <= override_req_in;
        end
    end
endmodule : rlc_far_side

// >>> sim/rlc_lane_regs_tb_top.sv
// ============================================================================
// rlc_lane_regs_tb_top - self-checking bench for the lane b3 register slice
// assumes the single-cycle strobe register port and the far-side model
`timescale 1ns/1ps

module rlc_lane_regs_tb_top;
    import rlc_pkg::*;
    logic        clk_in   = 1'b0;
    logic        rst_n_in = 1'b0;
    logic        wr_en    = 1'b0;
    logic        rd_en    = 1'b0;
    logic [7:0]  addr     = 8'h00;
    logic [7:0]  wdata    = 8'h00;
    logic        pres_req = 1'b0;
    logic [1:0]  pin_req  = 2'h0;
    logic        ovr_req  = 1'b0;
    logic        pres;
    logic [1:0]  pin;
    logic        ovr;
    logic [7:0]  rdata;
    logic [2:0]  deemph;
    logic [7:0]  tenth;
    logic [10:0] scale;
    logic [7:0]  amv;
    logic [7:0]  dmv;
    logic [1:0]  high;
    logic [1:0]  fast;
    logic [1:0]  gain;
    int          failures = 0;
    int          n_checks = 0;
    logic [7:0]  tenth_x [0:7] = '{8'h00, 8'h0F, 8'h23, 8'h32, 8'h3C, 8'h50, 8'h5A, 8'h78};
    logic [7:0]  amv_x   [0:3] = '{8'h32, 8'h28, 8'h4B, 8'h3A};
    logic [7:0]  dmv_x   [0:3] = '{8'h25, 8'h16, 8'h37, 8'h2D};
    logic [7:0]  ctl_x   [0:3] = '{8'h3F, 8'h00, 8'h2A, 8'h15};
    logic [7:0]  dead_x  [0:3] = '{8'h29, 8'h2A, 8'h30, 8'hFF};

    // ========================================================================
    // clock and instances
    // ========================================================================
    always #25 clk_in = ~clk_in;

    rlc_far_side far_u (.clk_in(clk_in), .rst_n_in(rst_n_in), .presence_req_in(pres_req),
        .pin_code_req_in(pin_req), .override_req_in(ovr_req),
        .receiver_presence_sense_out(pres), .detect_threshold_select_out(pin),
        .threshold_override_out(ovr));

    rlc_lane_regs dut_u (.clk_in(clk_in), .rst_n_in(rst_n_in), .reg_wr_en_in(wr_en),
        .reg_rd_en_in(rd_en), .reg_addr_in(addr), .reg_wdata_in(wdata),
        .reg_rdata_out(rdata), .threshold_override_in(ovr),
        .detect_threshold_select_in(pin), .receiver_presence_sense_in(pres),
        .output_deemphasis_out(deemph), .deemph_tenth_db_out(tenth),
        .output_swing_scale_out(scale), .assert_thresh_mv_out(amv),
        .deassert_thresh_mv_out(dmv), .high_range_en_out(high),
        .fast_detect_en_out(fast), .reduced_gain_en_out(gain));

    // ========================================================================
    // bus tasks and comparison
    // ========================================================================
    task automatic chk(input string what, input logic [10:0] seen, input logic [10:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("wrong value %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : chk

    // strobes stay one cycle; a following call waits for a fresh edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_in);
        wr_en <= 1'b1;
        addr  <= a;
        wdata <= d;
        @(posedge clk_in);
        wr_en <= 1'b0;
    endtask : wr

    task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk_in);
        rd_en <= 1'b1;
        addr  <= a;
        @(posedge clk_in);
        rd_en <= 1'b0;
        #1;
        chk("rdata", 11'(rdata), 11'(exp));
    endtask : rdc

    // lane outputs follow a write two edges later
    task automatic settle;
        repeat (2) @(posedge clk_in);
        #1;
    endtask : settle

    task automatic close_out;
        $display("checks %0d mismatches %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : close_out

    // ========================================================================
    // tests
    // ========================================================================
    initial
    begin
        repeat (6) @(posedge clk_in);
        rst_n_in <= 1'b1;
        #1;
        chk("deemph", 11'(deemph), 11'h2);
        chk("tenth", 11'(tenth), 11'h23);
        chk("scale", scale, 11'h2AC);
        chk("high", 11'(high), 11'h0);
        chk("fast", 11'(fast), 11'h3);
        chk("gain", 11'(gain), 11'h0);
        chk("amv", 11'(amv), 11'h32);
        chk("dmv", 11'(dmv), 11'h25);
        rdc(RLC_OFS_DEEMPH, 8'h02);
        rdc(RLC_OFS_THRESH, 8'h00);
        rdc(RLC_OFS_SD_CTRL, 8'h4C);
        $display("test reset done");
        // every code, reserved bits 6:3 written high to show they drop
        for (int i = 0; i < 8; i++)
        begin
            wr(RLC_OFS_DEEMPH, 8'h78 | 8'(i));
            settle;
            chk("deemph", 11'(deemph), 11'(i));
            chk("tenth", 11'(tenth), 11'(tenth_x[i]));
            chk("scale", scale, RLC_SWING_SCALE[i]);
            rdc(RLC_OFS_DEEMPH, 8'(i));
        end
        pres_req <= 1'b1;
        repeat (4) @(posedge clk_in);
        rdc(RLC_OFS_DEEMPH, 8'h87);
        pres_req <= 1'b0;
        repeat (4) @(posedge clk_in);
        rdc(RLC_OFS_DEEMPH, 8'h07);
        $display("test deemphasis done");
        ovr_req <= 1'b1;
        for (int i = 0; i < 16; i++)
        begin
            wr(RLC_OFS_THRESH, 8'hF0 | 8'(i));
            settle;
            chk("amv", 11'(amv), 11'(amv_x[i / 4]));
            chk("dmv", 11'(dmv), 11'(dmv_x[i % 4]));
            rdc(RLC_OFS_THRESH, 8'(i));
        end
        // register code chosen so every pin code differs in some field
        wr(RLC_OFS_THRESH, 8'h06);
        ovr_req <= 1'b0;
        for (int p = 0; p < 4; p++)
        begin
            pin_req <= 2'(p);
            repeat (5) @(posedge clk_in);
            #1;
            chk("amv", 11'(amv), 11'(amv_x[p]));
            chk("dmv", 11'(dmv), 11'(dmv_x[p]));
        end
        ovr_req <= 1'b1;
        repeat (3) @(posedge clk_in);
        #1;
        chk("amv", 11'(amv), 11'h28);
        chk("dmv", 11'(dmv), 11'h37);
        $display("test thresholds done");
        for (int i = 0; i < 4; i++)
        begin
            wr(RLC_OFS_SD_CTRL, 8'h40 | ctl_x[i]);
            settle;
            chk("high", 11'(high), 11'(ctl_x[i][5:4]));
            chk("fast", 11'(fast), 11'(ctl_x[i][3:2]));
            chk("gain", 11'(gain), 11'(ctl_x[i][1:0]));
            rdc(RLC_OFS_SD_CTRL, 8'h40 | ctl_x[i]);
        end
        wr(RLC_OFS_SD_CTRL, 8'hBF);
        rdc(RLC_OFS_SD_CTRL, 8'h7F);
        $display("test control done");
        for (int i = 0; i < 4; i++)
        begin
            wr(dead_x[i], 8'hFF);
            rdc(dead_x[i], 8'h00);
        end
        rdc(RLC_OFS_DEEMPH, 8'h07);
        rdc(RLC_OFS_THRESH, 8'h06);
        $display("test reserved done");
        close_out;
    end

    // hang guard: the tests need well under a thousand cycles
    initial
    begin
        repeat (5000) @(posedge clk_in);
        failures++;
        $display("watchdog expired");
        close_out;
    end
endmodule : rlc_lane_regs_tb_top
